//--- logic/mac_if_pkg.sv
`default_nettype none

package mac_if_pkg;

    typedef enum logic [1:0] {
        MODE_MII,
        MODE_RMII,
        MODE_SERIAL
    } mac_mode_t;

    // System clock period, 200 MHz.
    localparam int SYS_PERIOD_PS = 5000;

    // Periods of the generated clocks.
    localparam int PERIOD_25M_PS  = 40000;
    localparam int PERIOD_2P5M_PS = 400000;
    localparam int PERIOD_10M_PS  = 100000;

    // Half periods in system cycles.
    localparam logic [6:0] HALF_25M  = 7'(PERIOD_25M_PS / (2 * SYS_PERIOD_PS));
    localparam logic [6:0] HALF_2P5M = 7'(PERIOD_2P5M_PS / (2 * SYS_PERIOD_PS));
    localparam logic [6:0] HALF_10M  = 7'(PERIOD_10M_PS / (2 * SYS_PERIOD_PS));

    // Heartbeat length.
    localparam int HEARTBEAT_US = 1;
    localparam logic [7:0] HB_CYCLES = 8'(HEARTBEAT_US * 1000000 / SYS_PERIOD_PS);

    // Values after reset.
    localparam logic [3:0] NIBBLE_RESET = 4'h0;
    localparam logic [6:0] DIV_CNT_RESET = 7'h00;
    localparam logic [7:0] HB_CNT_RESET = 8'h00;

endpackage

`default_nettype wire

//--- logic/clk_div_if.sv
`default_nettype none

interface clk_div_if;
    logic       run;
    logic       restart;
    logic [6:0] half;
    logic       level;
    logic       rise;
    logic       fall;

    modport gen  (input run, input restart, input half, output level, output rise, output fall);
    modport user (output run, output restart, output half, input level, input rise, input fall);
endinterface

`default_nettype wire

//--- logic/clk_divider.sv
`default_nettype none

module clk_divider (
    // Clock and reset
    input  wire logic  clk_in,
    input  wire logic  srst_in,
    // Control and generated clock
    clk_div_if.gen     div
);

    logic [6:0] cnt_reg;
    logic       level_reg;
    logic       rise_reg;
    logic       fall_reg;
    logic       toggle;

    // A compare rather than an equality keeps a speed change from stranding the count.
    assign toggle = (cnt_reg >= div.half - 7'h01);

    always_ff @(posedge clk_in) begin
        if (srst_in || !div.run || div.restart) begin
            cnt_reg   <= mac_if_pkg::DIV_CNT_RESET;
            level_reg <= 1'b0;
            rise_reg  <= 1'b0;
            fall_reg  <= 1'b0;
        end else if (toggle) begin
            cnt_reg   <= mac_if_pkg::DIV_CNT_RESET;
            level_reg <= !level_reg;
            rise_reg  <= !level_reg;
            fall_reg  <= level_reg;
        end else begin
            cnt_reg  <= cnt_reg + 7'h01;
            rise_reg <= 1'b0;
            fall_reg <= 1'b0;
        end
    end

    assign div.level = level_reg;
    assign div.rise  = rise_reg;
    assign div.fall  = fall_reg;

endmodule

`default_nettype wire

//--- logic/mac_data_port.sv
// Overview of operation
// - MII transmit clock 25 or 2.5 MHz.
// - RMII: clocks unused, reference times transfers.
// - Serial mode drives 10 MHz transmit clock.
// - MII receive clock recovered, 25 or 2.5.
// - Serial mode receive clock is 10 MHz.
// - MII receive nibbles valid while valid high.
// - Receive valid follows data valid in MII and RMII, held low in serial.
// - RMII two bits on reference, valid kept.
// - MII 100M invalid symbol raises receive error.
// - RMII 100M error on symbol or false carrier.
// - RMII corrupts data on receive error.
// - Serial: bit zero only, others unused.
// - Carrier sense high while medium non-idle.
// - RMII merges carrier and valid, no collision.
// - Half duplex collision on simultaneous activity.
// - 10M half duplex heartbeat pulse one microsecond.
// - Full duplex collision always low.
// - Mode latched from two reset straps.
`default_nettype none

module mac_data_port (
    // Clock and reset
    input  wire logic       SYS_CLK_IN,
    input  wire logic       SRST_IN,
    // Reset straps
    input  wire logic       IFACE_SEL_STRAP_IN,
    input  wire logic       SERIAL_IFACE_STRAP_IN,
    // Link configuration
    input  wire logic       SPEED_100_IN,
    input  wire logic       FULL_DUPLEX_IN,
    input  wire logic       HEARTBEAT_EN_IN,
    input  wire logic       REFERENCE_CLOCK_INPUT_IN,
    // Transmit from the MAC
    input  wire logic       TX_EN_IN,
    input  wire logic [3:0] TXD_IN,
    // Clocks, receive and collision toward the MAC
    output var  logic       TX_CLK_OUT,
    output var  logic       RX_CLK_OUT,
    output var  logic       RX_DV_OUT,
    output var  logic       RX_ER_OUT,
    output var  logic [3:0] RXD_OUT,
    output var  logic       CRS_OUT,
    output var  logic       COL_OUT,
    // Line side receive
    input  wire logic       LINE_CARRIER_IN,
    input  wire logic       LINE_RX_DV_IN,
    input  wire logic [3:0] LINE_RX_DATA_IN,
    input  wire logic       LINE_RX_SYM_ERR_IN,
    input  wire logic       LINE_FALSE_CARRIER_IN,
    // Line side transmit
    output var  logic       LINE_TX_EN_OUT,
    output var  logic [3:0] LINE_TX_DATA_OUT,
    output var  logic       LINE_TX_STROBE_OUT
);

    ////////////////////////////////////////////////////////////////////////////////

    mac_if_pkg::mac_mode_t mode_reg;
    logic                  ref_prev_reg;
    logic                  ref_rise;
    logic                  carrier_prev_reg;
    logic                  tx_en_prev_reg;
    logic [7:0]            hb_cnt_reg;
    logic                  is_rmii;
    logic                  is_serial;
    logic                  is_10m;
    logic                  rx_err;
    logic [1:0]            line_bits;

    clk_div_if tx_div ();
    clk_div_if rx_div ();

    function automatic logic [6:0] half_for(input mac_if_pkg::mac_mode_t m, input logic fast);
        logic [6:0] h;
        h = mac_if_pkg::HALF_2P5M;
        if (m == mac_if_pkg::MODE_SERIAL) begin
            h = mac_if_pkg::HALF_10M;
        end else if (fast) begin
            h = mac_if_pkg::HALF_25M;
        end
        return h;
    endfunction

    assign is_rmii   = (mode_reg == mac_if_pkg::MODE_RMII);
    assign is_serial = (mode_reg == mac_if_pkg::MODE_SERIAL);
    assign is_10m    = is_serial || !SPEED_100_IN;
    assign ref_rise  = REFERENCE_CLOCK_INPUT_IN && !ref_prev_reg;
    assign line_bits = LINE_RX_DATA_IN[1:0];

    ////////////////////////////////////////////////////////////////////////////////
    // Straps are sampled for as long as reset is held, so the last value before release wins.

    always_ff @(posedge SYS_CLK_IN) begin
        if (SRST_IN) begin
            if (!IFACE_SEL_STRAP_IN) begin
                mode_reg <= mac_if_pkg::MODE_MII;
            end else if (!SERIAL_IFACE_STRAP_IN) begin
                mode_reg <= mac_if_pkg::MODE_RMII;
            end else begin
                mode_reg <= mac_if_pkg::MODE_SERIAL;
            end
        end
    end

    always_ff @(posedge SYS_CLK_IN) begin
        if (SRST_IN) begin
            ref_prev_reg     <= 1'b0;
            carrier_prev_reg <= 1'b0;
        end else begin
            ref_prev_reg     <= REFERENCE_CLOCK_INPUT_IN;
            carrier_prev_reg <= LINE_CARRIER_IN;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Clock generation. In RMII both dividers stop and hold their outputs low.

    assign tx_div.run     = !is_rmii;
    assign tx_div.restart = 1'b0;
    assign tx_div.half    = half_for(mode_reg, SPEED_100_IN);
    assign rx_div.run     = !is_rmii;
    // The receive clock is realigned to the line at the start of each carrier.
    assign rx_div.restart = LINE_CARRIER_IN && !carrier_prev_reg;
    assign rx_div.half    = half_for(mode_reg, SPEED_100_IN);

    clk_divider u_tx_div (
        .clk_in  (SYS_CLK_IN),
        .srst_in (SRST_IN),
        .div     (tx_div)
    );

    clk_divider u_rx_div (
        .clk_in  (SYS_CLK_IN),
        .srst_in (SRST_IN),
        .div     (rx_div)
    );

    assign TX_CLK_OUT = tx_div.level;
    assign RX_CLK_OUT = rx_div.level;

    ////////////////////////////////////////////////////////////////////////////////
    // Transmit path. The MAC's inputs are taken at the rising edge it times them to.

    always_ff @(posedge SYS_CLK_IN) begin
        if (SRST_IN) begin
            LINE_TX_EN_OUT     <= 1'b0;
            LINE_TX_DATA_OUT   <= mac_if_pkg::NIBBLE_RESET;
            LINE_TX_STROBE_OUT <= 1'b0;
        end else begin
            LINE_TX_STROBE_OUT <= 1'b0;
            unique case (mode_reg)
                mac_if_pkg::MODE_MII: begin
                    if (tx_div.rise) begin
                        LINE_TX_EN_OUT     <= TX_EN_IN;
                        LINE_TX_DATA_OUT   <= TXD_IN;
                        LINE_TX_STROBE_OUT <= 1'b1;
                    end
                end
                mac_if_pkg::MODE_RMII: begin
                    if (ref_rise) begin
                        LINE_TX_EN_OUT     <= TX_EN_IN;
                        LINE_TX_DATA_OUT   <= {2'h0, TXD_IN[1:0]};
                        LINE_TX_STROBE_OUT <= 1'b1;
                    end
                end
                mac_if_pkg::MODE_SERIAL: begin
                    if (tx_div.rise) begin
                        LINE_TX_EN_OUT     <= TX_EN_IN;
                        LINE_TX_DATA_OUT   <= {3'h0, TXD_IN[0]};
                        LINE_TX_STROBE_OUT <= 1'b1;
                    end
                end
                default: begin
                    LINE_TX_EN_OUT <= 1'b0;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Receive path. MII and serial data change on the falling edge so they are stable
    // at the rising edge where the MAC samples them.

    assign rx_err = SPEED_100_IN && ((LINE_RX_SYM_ERR_IN && (LINE_CARRIER_IN || LINE_RX_DV_IN))
                    || LINE_FALSE_CARRIER_IN);

    always_ff @(posedge SYS_CLK_IN) begin
        if (SRST_IN) begin
            RX_DV_OUT <= 1'b0;
            RX_ER_OUT <= 1'b0;
            RXD_OUT   <= mac_if_pkg::NIBBLE_RESET;
            CRS_OUT   <= 1'b0;
        end else begin
            unique case (mode_reg)
                mac_if_pkg::MODE_MII: begin
                    CRS_OUT <= LINE_CARRIER_IN;
                    if (rx_div.fall) begin
                        RX_DV_OUT <= LINE_RX_DV_IN;
                        RXD_OUT   <= LINE_RX_DATA_IN;
                        RX_ER_OUT <= SPEED_100_IN && LINE_RX_DV_IN && LINE_RX_SYM_ERR_IN;
                    end
                end
                mac_if_pkg::MODE_RMII: begin
                    if (ref_rise) begin
                        CRS_OUT   <= LINE_CARRIER_IN || LINE_RX_DV_IN;
                        RX_DV_OUT <= LINE_RX_DV_IN;
                        RX_ER_OUT <= rx_err;
                        // A MAC that ignores the error pin still sees a broken frame.
                        RXD_OUT   <= {2'h0, rx_err ? ~line_bits : line_bits};
                    end
                end
                mac_if_pkg::MODE_SERIAL: begin
                    RX_DV_OUT    <= 1'b0;
                    RX_ER_OUT    <= 1'b0;
                    RXD_OUT[3:1] <= 3'h0;
                    if (rx_div.fall) begin
                        CRS_OUT    <= LINE_CARRIER_IN;
                        RXD_OUT[0] <= LINE_RX_DATA_IN[0];
                    end
                end
                default: begin
                    RX_DV_OUT <= 1'b0;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Heartbeat timer, started when a 10 Mb/s half-duplex transmission ends.

    always_ff @(posedge SYS_CLK_IN) begin
        if (SRST_IN) begin
            tx_en_prev_reg <= 1'b0;
            hb_cnt_reg     <= mac_if_pkg::HB_CNT_RESET;
        end else begin
            tx_en_prev_reg <= LINE_TX_EN_OUT;
            if (tx_en_prev_reg && !LINE_TX_EN_OUT && is_10m && !is_rmii
                && !FULL_DUPLEX_IN && HEARTBEAT_EN_IN) begin
                hb_cnt_reg <= mac_if_pkg::HB_CYCLES;
            end else if (hb_cnt_reg != 8'h00) begin
                hb_cnt_reg <= hb_cnt_reg - 8'h01;
            end
        end
    end

    // Collision is suppressed outright in full duplex and RMII, which also cuts a running
    // heartbeat short if the duplex setting changes mid-pulse.
    always_ff @(posedge SYS_CLK_IN) begin
        if (SRST_IN) begin
            COL_OUT <= 1'b0;
        end else if (FULL_DUPLEX_IN || is_rmii) begin
            COL_OUT <= 1'b0;
        end else begin
            COL_OUT <= (LINE_TX_EN_OUT && LINE_CARRIER_IN)
                       || (hb_cnt_reg != 8'h00);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////

    property p_strap_rmii;
        @(posedge SYS_CLK_IN) SRST_IN && IFACE_SEL_STRAP_IN && !SERIAL_IFACE_STRAP_IN
            |=> mode_reg == mac_if_pkg::MODE_RMII;
    endproperty
    a_strap_rmii: assert property (p_strap_rmii) else $error("straps not latched");

    property p_rmii_quiet;
        @(posedge SYS_CLK_IN) disable iff (SRST_IN)
            is_rmii |=> !TX_CLK_OUT && !RX_CLK_OUT && !COL_OUT;
    endproperty
    a_rmii_quiet: assert property (p_rmii_quiet) else $error("rmii clock or col active");

    property p_fdx_col;
        @(posedge SYS_CLK_IN) disable iff (SRST_IN) FULL_DUPLEX_IN |=> !COL_OUT;
    endproperty
    a_fdx_col: assert property (p_fdx_col) else $error("collision in full duplex");

    property p_tx_clk_25m;
        @(posedge SYS_CLK_IN) disable iff (SRST_IN)
            $rose(TX_CLK_OUT) && !is_rmii && !is_serial && SPEED_100_IN
            |-> TX_CLK_OUT[*4] ##1 !TX_CLK_OUT;
    endproperty
    a_tx_clk_25m: assert property (p_tx_clk_25m) else $error("tx clock not 25 MHz");

    property p_tx_clk_10m;
        @(posedge SYS_CLK_IN) disable iff (SRST_IN)
            $rose(TX_CLK_OUT) && is_serial |-> ##9 TX_CLK_OUT ##1 !TX_CLK_OUT;
    endproperty
    a_tx_clk_10m: assert property (p_tx_clk_10m) else $error("tx clock not 10 MHz");

    property p_serial_unused;
        @(posedge SYS_CLK_IN) disable iff (SRST_IN)
            is_serial |=> !RX_DV_OUT && !RX_ER_OUT && RXD_OUT[3:1] == 3'h0;
    endproperty
    a_serial_unused: assert property (p_serial_unused) else $error("serial unused pins");

    property p_rmii_corrupt;
        @(posedge SYS_CLK_IN) disable iff (SRST_IN)
            is_rmii && ref_rise && SPEED_100_IN && LINE_RX_SYM_ERR_IN && LINE_RX_DV_IN
            |=> RX_ER_OUT && RXD_OUT[1:0] != $past(line_bits);
    endproperty
    a_rmii_corrupt: assert property (p_rmii_corrupt) else $error("rmii data not corrupted");

    property p_mii_rx_er;
        @(posedge SYS_CLK_IN) disable iff (SRST_IN)
            mode_reg == mac_if_pkg::MODE_MII && rx_div.fall && SPEED_100_IN
            && LINE_RX_DV_IN && LINE_RX_SYM_ERR_IN |=> RX_ER_OUT && RX_DV_OUT;
    endproperty
    a_mii_rx_er: assert property (p_mii_rx_er) else $error("mii receive error missing");

    property p_heartbeat;
        @(posedge SYS_CLK_IN) disable iff (SRST_IN)
            $fell(LINE_TX_EN_OUT) && is_10m && !is_rmii && !FULL_DUPLEX_IN && HEARTBEAT_EN_IN
            |=> hb_cnt_reg == mac_if_pkg::HB_CYCLES ##1 COL_OUT;
    endproperty
    a_heartbeat: assert property (p_heartbeat) else $error("heartbeat not started");

    property p_collision;
        @(posedge SYS_CLK_IN) disable iff (SRST_IN)
            LINE_TX_EN_OUT && LINE_CARRIER_IN && !FULL_DUPLEX_IN && !is_rmii |=> COL_OUT;
    endproperty
    a_collision: assert property (p_collision) else $error("collision not flagged");

    property p_mii_crs;
        @(posedge SYS_CLK_IN) disable iff (SRST_IN)
            mode_reg == mac_if_pkg::MODE_MII |=> CRS_OUT == $past(LINE_CARRIER_IN);
    endproperty
    a_mii_crs: assert property (p_mii_crs) else $error("mii carrier sense wrong");

    property p_rmii_merge;
        @(posedge SYS_CLK_IN) disable iff (SRST_IN)
            is_rmii && ref_rise |=> CRS_OUT == $past(LINE_CARRIER_IN || LINE_RX_DV_IN);
    endproperty
    a_rmii_merge: assert property (p_rmii_merge) else $error("rmii merged carrier wrong");

endmodule

`default_nettype wire

//--- tb/mac_model.sv
`default_nettype none

module mac_model (
    // Clock and slot timing
    input  wire logic       clk_in,
    input  wire logic       slot_clk_in,
    // Transmit toward the device
    output var  logic       tx_en_out,
    output var  logic [3:0] txd_out
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [3:0] queue_q[$];
    logic       slot_prev = 1'b0;

    task automatic push(input logic [3:0] nibble);
        queue_q.push_back(nibble);
    endtask

    initial begin
        tx_en_out = 1'b0;
        txd_out   = 4'h0;
    end

    ////////////////////////////////////////////////////////////////////////
    // Data moves just after the slot clock falls, half a period before capture.
    // Unused data bits carry whatever the caller pushed, so masking is exercised.
    always @(negedge clk_in) begin
        if (slot_prev && !slot_clk_in) begin
            if (queue_q.size() > 0) begin
                tx_en_out <= 1'b1;
                txd_out   <= queue_q.pop_front();
            end else begin
                tx_en_out <= 1'b0;
                txd_out   <= ~txd_out;
            end
        end
        slot_prev <= slot_clk_in;
    end
endmodule

`default_nettype wire

//--- tb/phy_mac_data_interface_test.sv
`default_nettype none

module phy_mac_data_interface_test;
    timeunit 1ns;
    timeprecision 1ps;

    logic       clk = 1'b0;
    logic       srst = 1'b1;
    logic       sel_strap = 1'b0;
    logic       ser_strap = 1'b0;
    logic       speed_100 = 1'b1;
    logic       full_dup = 1'b0;
    logic       hb_en = 1'b0;
    logic [1:0] ref_cnt = 2'h0;
    logic       carrier = 1'b0;
    logic       line_dv = 1'b0;
    logic [3:0] line_data = 4'h0;
    logic       sym_err = 1'b0;
    logic       false_car = 1'b0;
    logic       rmii = 1'b0;
    logic       tx_en;
    logic [3:0] txd;
    logic       tx_clk;
    logic       rx_clk;
    logic       dv;
    logic       er;
    logic [3:0] rxd;
    logic       crs;
    logic       col;
    logic       ltx_en;
    logic [3:0] ltx_data;
    logic       strobe;
    logic       mac_slot;
    logic       rx_slot;
    logic [4:0] caps[$];
    int         checks = 0;
    int         mismatches = 0;

    assign mac_slot = rmii ? ref_cnt[1] : tx_clk;
    assign rx_slot  = rmii ? ref_cnt[1] : ~rx_clk;

    always #2.5 clk = ~clk;
    always @(negedge clk) ref_cnt <= ref_cnt + 2'h1;
    always @(negedge clk) if (strobe === 1'b1) caps.push_back({ltx_en, ltx_data});

    mac_data_port i_dut (
        .SYS_CLK_IN(clk), .SRST_IN(srst),
        .IFACE_SEL_STRAP_IN(sel_strap), .SERIAL_IFACE_STRAP_IN(ser_strap),
        .SPEED_100_IN(speed_100), .FULL_DUPLEX_IN(full_dup), .HEARTBEAT_EN_IN(hb_en),
        .REFERENCE_CLOCK_INPUT_IN(ref_cnt[1]), .TX_EN_IN(tx_en), .TXD_IN(txd),
        .TX_CLK_OUT(tx_clk), .RX_CLK_OUT(rx_clk), .RX_DV_OUT(dv), .RX_ER_OUT(er),
        .RXD_OUT(rxd), .CRS_OUT(crs), .COL_OUT(col),
        .LINE_CARRIER_IN(carrier), .LINE_RX_DV_IN(line_dv), .LINE_RX_DATA_IN(line_data),
        .LINE_RX_SYM_ERR_IN(sym_err), .LINE_FALSE_CARRIER_IN(false_car),
        .LINE_TX_EN_OUT(ltx_en), .LINE_TX_DATA_OUT(ltx_data), .LINE_TX_STROBE_OUT(strobe)
    );

    mac_model i_mac (.clk_in(clk), .slot_clk_in(mac_slot), .tx_en_out(tx_en), .txd_out(txd));

    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        checks++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wait_for(ref logic s, input logic v);
        int n;
        n = 0;
        while (s !== v && n < 900) begin
            @(negedge clk);
            n++;
        end
        if (s !== v) chk("handshake wait", 8'h01, 8'h00);
    endtask

    task automatic restart(input logic sel, input logic ser);
        srst = 1'b1;
        sel_strap = sel;
        ser_strap = ser;
        rmii = sel & ~ser;
        repeat (3) @(negedge clk);
        chk("outputs in reset", 8'h00, {tx_clk, rx_clk, dv, er, crs, col, ltx_en, strobe});
        repeat (7) @(negedge clk);
        srst = 1'b0;
    endtask

    // Counts cycles between two rises; a stuck clock fails after the guard.
    task automatic period(input string what, input logic use_rx, input logic [7:0] exp);
        logic prev;
        logic cur;
        int   n;
        int   edges;
        int   guard;
        prev = 1'b1;
        n = 0;
        edges = 0;
        guard = 0;
        while (edges < 2 && guard < 400) begin
            @(negedge clk);
            guard++;
            cur = use_rx ? rx_clk : tx_clk;
            if (cur === 1'b1 && prev === 1'b0) begin
                edges++;
                if (edges == 2) chk(what, exp, 8'(n));
                n = 0;
            end
            n++;
            prev = cur;
        end
        if (edges < 2) chk(what, exp, 8'h00);
    endtask

    task automatic send2(input string what, input logic [3:0] a, input logic [3:0] b,
                         input logic [3:0] m);
        logic [4:0] got[$];
        int         guard;
        caps.delete();
        i_mac.push(a);
        i_mac.push(b);
        guard = 0;
        while (got.size() < 3 && guard < 900) begin
            @(negedge clk);
            guard++;
            while (caps.size() > 0) begin
                if (caps[0][4] === 1'b1 || got.size() > 0) got.push_back(caps[0]);
                caps.pop_front();
            end
        end
        chk(what, 8'({1'b1, a & m}), 8'(got[0]));
        chk(what, 8'({1'b1, b & m}), 8'(got[1]));
        chk(what, 8'h00, 8'(got[2][4]));
    endtask

    // Expected is {crs, dv, er, rxd}, sampled once the slot's update has landed.
    task automatic receive(input string what, input logic c, input logic v, input logic [3:0] d,
                           input logic se, input logic fc, input logic [6:0] exp);
        carrier = c;
        line_dv = v;
        line_data = d;
        sym_err = se;
        false_car = fc;
        // Two edges let a carrier rise realign the receive clock before its slot is tracked.
        repeat (2) @(negedge clk);
        wait_for(rx_slot, 1'b0);
        wait_for(rx_slot, 1'b1);
        repeat (2) @(negedge clk);
        chk(what, {1'b0, exp}, {1'b0, crs, dv, er, rxd});
        {carrier, line_dv, sym_err, false_car} = 4'h0;
    endtask

    task automatic collide(input string what, input logic exp_col, input logic exp_hb);
        int n;
        // A heartbeat left over from the last frame would hide both checks below.
        wait_for(col, 1'b0);
        repeat (4) i_mac.push(4'h5);
        wait_for(ltx_en, 1'b1);
        carrier = 1'b1;
        repeat (4) @(negedge clk);
        chk(what, 8'(exp_col), 8'(col));
        if (rmii) chk("mac derived collision", 8'h01, 8'({tx_en & crs}));
        carrier = 1'b0;
        wait_for(ltx_en, 1'b0);
        n = 0;
        if (exp_hb) begin
            wait_for(col, 1'b1);
            while (col === 1'b1 && n < 300) begin
                @(negedge clk);
                n++;
            end
            chk(what, mac_if_pkg::HB_CYCLES, 8'(n));
        end else begin
            repeat (6) @(negedge clk);
            chk(what, 8'h00, 8'(col));
        end
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    initial begin
        #100us;
        mismatches++;
        give_verdict();
    end

    initial begin
        restart(1'b0, 1'b0);
        period("mii tx clk 100", 1'b0, 8'(2 * mac_if_pkg::HALF_25M));
        period("mii rx clk 100", 1'b1, 8'(2 * mac_if_pkg::HALF_25M));
        send2("mii transmit", 4'ha, 4'h5, 4'hf);
        receive("mii receive error", 1'b1, 1'b1, 4'hc, 1'b1, 1'b0, 7'h7c);
        collide("mii collision", 1'b1, 1'b0);
        // The speed moves just after a clock rise, so that high phase runs to the slow length before the slow period is measured.
        wait_for(tx_clk, 1'b0);
        wait_for(tx_clk, 1'b1);
        speed_100 = 1'b0;
        period("mii tx clk 10", 1'b0, 8'(2 * mac_if_pkg::HALF_2P5M));
        receive("mii 10 no error", 1'b1, 1'b1, 4'h3, 1'b1, 1'b0, 7'h63);
        full_dup = 1'b1;
        hb_en = 1'b1;
        collide("full duplex", 1'b0, 1'b0);
        speed_100 = 1'b1;
        full_dup = 1'b0;
        restart(1'b1, 1'b0);
        chk("rmii clocks", 8'h00, {6'h00, tx_clk, rx_clk});
        send2("rmii transmit", 4'he, 4'h9, 4'h3);
        receive("rmii corrupt", 1'b1, 1'b1, 4'h1, 1'b1, 1'b0, 7'h72);
        receive("rmii false carrier", 1'b0, 1'b0, 4'h2, 1'b0, 1'b1, 7'h11);
        collide("rmii no collision", 1'b0, 1'b0);
        restart(1'b1, 1'b1);
        period("serial tx clk", 1'b0, 8'(2 * mac_if_pkg::HALF_10M));
        period("serial rx clk", 1'b1, 8'(2 * mac_if_pkg::HALF_10M));
        send2("serial transmit", 4'hf, 4'h6, 4'h1);
        receive("serial receive", 1'b1, 1'b1, 4'hf, 1'b1, 1'b0, 7'h41);
        collide("serial heartbeat", 1'b1, 1'b1);
        give_verdict();
    end
endmodule

`default_nettype wire
